/* File: rtl/lct_pkg.sv */
// Package for the counter/timer unit: register offsets, field positions,
// reset values, prescale figures and the shared state carriers.
// Assumes one system clock and synchronous event pins.
// How it works
// - A timer counts ticks of the system clock divided by one or twelve, as its clock-select bit says.
// - A counter counts falling edges of its pin, which must hold each level two clocks or more.
// - Timers zero and one each take a two-bit mode: 13-bit, 16-bit, 8-bit reload, or split bytes for zero.
// - Timers zero and one each hold a 16-bit count seen as a low and a high byte.
// - In 13-bit mode the high byte holds the top eight bits and low byte bits four to zero the rest.
// - A 13-bit rollover from all ones to zero sets that timer's overflow flag.
// - A counter-select bit for each of timers zero, one and two picks clock ticks when clear and pin falling edges when set.
// - Overflow flags at control bits seven and five are set by hardware, cleared by write or vectoring.
// - Run bits at control bits six and four stop a timer at zero and let it count at one.
// - Type bits at control bits two and zero pick low level at zero and falling edge at one.
// - External flags at bits three and one follow the inverted pin in level mode, latch edges otherwise.
// - Timer two is a 16-bit count whose counter-select bit picks divided ticks or its own pin.
// - Timer two decodes capture, auto-reload, baud generation or stop from its control bits.
// - Timer two overflow outside baud generation is offered as a start trigger for a data conversion.
// - Timer three is a 16-bit timer with auto-reload only.
// - Timer three reloads its low byte from the reload low-byte register.
package lct_pkg;
    // Register offsets and reset values on the special-function port
    localparam logic [7:0] LCT_ADDR_TCTRL   = 8'h88;
    localparam logic [7:0] LCT_ADDR_T3RLL   = 8'h92;
    localparam logic [7:0] LCT_RST_TCTRL    = 8'h00;
    localparam logic [7:0] LCT_RST_T3RLL    = 8'h00;
    // Control register bit positions
    localparam int LCT_TF1 = 7;
    localparam int LCT_TR1 = 6;
    localparam int LCT_TF0 = 5;
    localparam int LCT_TR0 = 4;
    localparam int LCT_IE1 = 3;
    localparam int LCT_IT1 = 2;
    localparam int LCT_IE0 = 1;
    localparam int LCT_IT0 = 0;
    // Mode register: timer zero in the low nibble, timer one in the high
    localparam int LCT_T1_NIB = 4;
    localparam int LCT_CS_POS = 2;
    // Timer two control bit positions
    localparam int LCT_T2_RXB  = 5;
    localparam int LCT_T2_TXB  = 4;
    localparam int LCT_T2_EXEN = 3;
    localparam int LCT_T2_RUN  = 2;
    localparam int LCT_T2_CS   = 1;
    localparam int LCT_T2_CPRL = 0;
    // Prescaler for the slow tick
    localparam int         LCT_DIV_SLOW = 12;
    localparam logic [3:0] LCT_DIV_LAST = 4'(LCT_DIV_SLOW - 1);
    // Count limits
    localparam logic [12:0] LCT_MAX13 = 13'h1fff;
    localparam logic [15:0] LCT_MAX16 = 16'hffff;
    localparam logic [7:0]  LCT_MAX8  = 8'hff;
    // Timer zero and one modes
    typedef enum logic [1:0] {
        LCT_M13   = 2'h0,
        LCT_M16   = 2'h1,
        LCT_M8RL  = 2'h2,
        LCT_SPLIT = 2'h3
    } lct_mode_t;
    // Result of one count step
    typedef struct packed {
        logic        ovf;
        logic [15:0] cnt;
    } lct_step_t;
    // Event pin sample pair
    typedef struct packed {
        logic cur;
        logic prev;
    } lct_pin_t;
endpackage

/* File: rtl/lct_tick_gen.sv */
// Free-running prescaler giving the divide-by-twelve tick.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module lct_tick_gen
    import lct_pkg::*;
(
    input  wire logic mclk_in,    // System clock
    input  wire logic rst_n_in,   // Async reset, active low
    output logic      slow_out    // One-cycle tick every twelfth clock
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // Next prescaler value
    always_comb begin
        cnt_d = (cnt_q == LCT_DIV_LAST) ? 4'h0 : cnt_q + 4'h1;
    end

    // Prescaler register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign slow_out = (cnt_q == LCT_DIV_LAST);
endmodule
`default_nettype wire

/* File: rtl/lct_fall_det.sv */
// Samples one event pin and flags its falling edges.
// Assumes the pin is synchronous to the clock and holds each level two clocks.
`timescale 1ns/1ps
`default_nettype none
module lct_fall_det
    import lct_pkg::*;
(
    input  wire logic mclk_in,    // System clock
    input  wire logic rst_n_in,   // Async reset, active low
    input  wire logic pin_in,     // Event pin level
    output logic      level_out,  // Sampled pin level
    output logic      fall_out    // High one cycle after a falling edge
);
    lct_pin_t st_q;
    lct_pin_t st_d;

    // Shift in the new sample
    always_comb begin
        st_d.cur  = pin_in;
        st_d.prev = st_q.cur;
    end

    // Sample register, idle high
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.cur;
    assign fall_out  = st_q.prev & ~st_q.cur;
endmodule
`default_nettype wire

/* File: rtl/lct_timers.sv */
// Counter/timer unit: timers zero and one, timer two, timer three and the
// shared run and flag control register on the special-function port.
// Assumes synchronous pins and a CPU that pulses vector_ack_in on vectoring.
`timescale 1ns/1ps
`default_nettype none
module lct_timers
    import lct_pkg::*;
(
    input  wire logic        mclk_in,         // System clock, 50 MHz
    input  wire logic        rst_n_in,        // Async reset, active low
    input  wire logic [7:0]  sfr_addr_in,     // Register address
    input  wire logic        sfr_wr_in,       // Write strobe
    input  wire logic [7:0]  sfr_wdata_in,    // Write data
    output logic      [7:0]  sfr_rdata_out,   // Read data, one cycle later
    input  wire logic [7:0]  timer_mode_in,   // Timer mode register
    input  wire logic [3:0]  clk_sel_in,      // One per timer: 1 = sysclk, 0 = /12
    input  wire logic [7:0]  timer_two_control_in, // Timer two control
    input  wire logic        timer_three_run_in,   // Timer three run
    input  wire logic [7:0]  t3_reload_high_in,    // Timer three reload high
    input  wire logic [15:0] t2_reload_in,    // Timer two reload value
    input  wire logic [3:0]  load_sel_in,     // Load pulse per timer
    input  wire logic [15:0] load_value_in,   // Value for a load
    input  wire logic        t0_pin_in,       // Timer zero event pin
    input  wire logic        t1_pin_in,       // Timer one event pin
    input  wire logic        t2_pin_in,       // Timer two event pin
    input  wire logic        t2_ext_pin_in,   // Timer two capture/reload pin
    input  wire logic        ext_irq_zero_pin_in, // Ext interrupt zero, active low
    input  wire logic        ext_irq_one_pin_in,  // Ext interrupt one, active low
    input  wire logic [3:0]  vector_ack_in,   // Vectoring: tf1, tf0, ie1, ie0
    output logic      [7:0]  tctrl_out,       // Run and flag control byte
    output logic      [15:0] t0_count_out,    // Timer zero high:low
    output logic      [15:0] t1_count_out,    // Timer one high:low
    output logic      [15:0] t2_count_out,    // Timer two high:low
    output logic      [15:0] t3_count_out,    // Timer three high:low
    output logic      [15:0] t2_capture_out,  // Timer two capture value
    output logic             t2_ovf_out,      // Timer two overflow pulse
    output logic             adc_start_out,   // Conversion start pulse
    output logic             baud_tx_out,     // Transmit baud pulse
    output logic             baud_rx_out,     // Receive baud pulse
    output logic             t3_ovf_out       // Timer three overflow pulse
);
    typedef struct packed {
        logic [7:0]  tctrl;
        logic [7:0]  t3rll;
        logic [15:0] t0;
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] t3;
        logic [15:0] t2cap;
        logic [7:0]  rdata;
        logic        t2ovf;
        logic        btx;
        logic        brx;
        logic        t3ovf;
    } lct_state_t;

    lct_state_t st_q;
    lct_state_t st_d;

    // One count step of timers zero and one in modes 0 to 2
    function automatic lct_step_t t01_step(input logic [15:0] cnt, input lct_mode_t md, input logic en);
        lct_step_t r;
        r.ovf = 1'b0;
        r.cnt = cnt;
        if (en) begin
            case (md)
                LCT_M13: begin
                    // five low bits in the low byte, rollover flags
                    r.ovf = ({cnt[15:8], cnt[4:0]} == LCT_MAX13);
                    r.cnt = {cnt[15:8] + 8'(&cnt[4:0]), cnt[7:5], cnt[4:0] + 5'h1};
                end
                LCT_M16: begin
                    r.ovf = (cnt == LCT_MAX16);
                    r.cnt = cnt + 16'h1;
                end
                LCT_M8RL: begin
                    r.ovf = (cnt[7:0] == LCT_MAX8);
                    r.cnt = {cnt[15:8], r.ovf ? cnt[15:8] : cnt[7:0] + 8'h1};
                end
                default: begin
                    r.cnt = cnt;
                end
            endcase
        end
        return r;
    endfunction

    // Tick source choice, used by every timer
    function automatic logic tick_of(input logic sel_fast, input logic slow);
        return sel_fast | slow;
    endfunction

    logic       slow_tick;
    logic [5:0] pin_vec;
    logic [5:0] pin_lvl;
    logic [5:0] pin_fall;

    lct_tick_gen u_tick (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .slow_out (slow_tick)
    );

    assign pin_vec = {t2_ext_pin_in, ext_irq_one_pin_in, ext_irq_zero_pin_in, t2_pin_in, t1_pin_in, t0_pin_in};

    // falling-edge sampling of every event pin
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            lct_fall_det u_fd (
                .mclk_in   (mclk_in),
                .rst_n_in  (rst_n_in),
                .pin_in    (pin_vec[gi]),
                .level_out (pin_lvl[gi]),
                .fall_out  (pin_fall[gi])
            );
        end
    endgenerate

    lct_mode_t m0;
    lct_mode_t m1;
    logic      cs0, cs1, cs2;
    logic      tk0, tk1, tk2, tk3;
    logic      en0, en1, en2, en3;
    logic      wr_tctrl, wr_t3rll;
    logic      t2_run, t2_baud, t2_cap_mode;
    lct_step_t s0, s1;
    logic      ovf_t0, ovf_t1, ovf_t2, ovf_t3;
    logic      th0_inc;
    logic [7:0] tc;

    // Mode fields and clock sources
    always_comb begin
        m0  = lct_mode_t'(timer_mode_in[1:0]);
        m1  = lct_mode_t'(timer_mode_in[LCT_T1_NIB +: 2]);
        cs0 = timer_mode_in[LCT_CS_POS];
        cs1 = timer_mode_in[LCT_T1_NIB + LCT_CS_POS];
        cs2 = timer_two_control_in[LCT_T2_CS];
        tk0 = tick_of(clk_sel_in[0], slow_tick);
        tk1 = tick_of(clk_sel_in[1], slow_tick);
        tk2 = tick_of(clk_sel_in[2], slow_tick);
        tk3 = tick_of(clk_sel_in[3], slow_tick);
        en0 = st_q.tctrl[LCT_TR0] & (cs0 ? pin_fall[0] : tk0);
        en1 = st_q.tctrl[LCT_TR1] & (cs1 ? pin_fall[1] : tk1) & (m1 != LCT_SPLIT);
        t2_run      = timer_two_control_in[LCT_T2_RUN];
        t2_baud     = timer_two_control_in[LCT_T2_RXB] | timer_two_control_in[LCT_T2_TXB];
        t2_cap_mode = ~t2_baud & timer_two_control_in[LCT_T2_CPRL];
        en2 = t2_run & (cs2 ? pin_fall[2] : tk2);
        // timer three is a plain timer
        en3 = timer_three_run_in & tk3;
        wr_tctrl = sfr_wr_in & (sfr_addr_in == LCT_ADDR_TCTRL);
        wr_t3rll = sfr_wr_in & (sfr_addr_in == LCT_ADDR_T3RLL);
    end

    // Next state of counts, flags and read data
    always_comb begin
        st_d = st_q;
        s0 = t01_step(st_q.t0, m0, en0);
        s1 = t01_step(st_q.t1, m1, en1);
        ovf_t0 = s0.ovf;
        ovf_t1 = s1.ovf;
        st_d.t0 = s0.cnt;
        st_d.t1 = s1.cnt;
        th0_inc = 1'b0;
        // split mode, high byte borrows timer one's run bit
        if (m0 == LCT_SPLIT) begin
            th0_inc = st_q.tctrl[LCT_TR1] & tk0;
            ovf_t0  = en0 & (st_q.t0[7:0] == LCT_MAX8);
            ovf_t1  = th0_inc & (st_q.t0[15:8] == LCT_MAX8);
            st_d.t0 = {st_q.t0[15:8] + 8'(th0_inc), st_q.t0[7:0] + 8'(en0)};
        end
        if (load_sel_in[0]) begin
            st_d.t0 = load_value_in;
        end
        if (load_sel_in[1]) begin
            st_d.t1 = load_value_in;
        end
        ovf_t2 = en2 & (st_q.t2 == LCT_MAX16);
        st_d.t2 = st_q.t2 + 16'(en2);
        if (ovf_t2 && !t2_cap_mode) begin
            st_d.t2 = t2_reload_in;
        end
        if (t2_run && !t2_baud && timer_two_control_in[LCT_T2_EXEN] && pin_fall[5]) begin
            if (t2_cap_mode) begin
                st_d.t2cap = st_q.t2;
            end else begin
                st_d.t2 = t2_reload_in;
            end
        end
        if (load_sel_in[2]) begin
            st_d.t2 = load_value_in;
        end
        st_d.t2ovf = ovf_t2 & ~t2_baud;
        st_d.btx   = ovf_t2 & timer_two_control_in[LCT_T2_TXB];
        st_d.brx   = ovf_t2 & timer_two_control_in[LCT_T2_RXB];
        // timer three reloads from the reload registers
        ovf_t3 = en3 & (st_q.t3 == LCT_MAX16);
        st_d.t3 = ovf_t3 ? {t3_reload_high_in, st_q.t3rll} : st_q.t3 + 16'(en3);
        if (load_sel_in[3]) begin
            st_d.t3 = load_value_in;
        end
        st_d.t3ovf = ovf_t3;
        if (wr_t3rll) begin
            st_d.t3rll = sfr_wdata_in;
        end
        // write or vectoring clears, hardware set wins
        tc = wr_tctrl ? sfr_wdata_in : st_q.tctrl;
        tc[LCT_TF1] = (tc[LCT_TF1] & ~vector_ack_in[3]) | ovf_t1;
        tc[LCT_TF0] = (tc[LCT_TF0] & ~vector_ack_in[2]) | ovf_t0;
        // type bit picks edge or level; flag behaviour
        if (tc[LCT_IT1]) begin
            tc[LCT_IE1] = (tc[LCT_IE1] & ~vector_ack_in[1]) | pin_fall[4];
        end else begin
            tc[LCT_IE1] = ~pin_lvl[4];
        end
        if (tc[LCT_IT0]) begin
            tc[LCT_IE0] = (tc[LCT_IE0] & ~vector_ack_in[0]) | pin_fall[3];
        end else begin
            tc[LCT_IE0] = ~pin_lvl[3];
        end
        st_d.tctrl = tc;
        // Registered read data, unmapped reads as zero
        case (sfr_addr_in)
            LCT_ADDR_TCTRL: st_d.rdata = st_q.tctrl;
            LCT_ADDR_T3RLL: st_d.rdata = st_q.t3rll;
            default:        st_d.rdata = 8'h00;
        endcase
    end

    // State register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q       <= '0;
            st_q.tctrl <= LCT_RST_TCTRL;
            st_q.t3rll <= LCT_RST_T3RLL;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata_out  = st_q.rdata;
    assign tctrl_out      = st_q.tctrl;
    assign t0_count_out   = st_q.t0;
    assign t1_count_out   = st_q.t1;
    assign t2_count_out   = st_q.t2;
    assign t3_count_out   = st_q.t3;
    assign t2_capture_out = st_q.t2cap;
    assign t2_ovf_out     = st_q.t2ovf;
    assign adc_start_out  = st_q.t2ovf;
    assign baud_tx_out    = st_q.btx;
    assign baud_rx_out    = st_q.brx;
    assign t3_ovf_out     = st_q.t3ovf;

    // Checks on the design's own behaviour
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_t0_tick;
        (m0 == LCT_M16 && !cs0 && clk_sel_in[0] && st_q.tctrl[LCT_TR0] && !load_sel_in[0] && st_q.t0 != LCT_MAX16)
            |=> st_q.t0 == 16'($past(st_q.t0) + 16'h1);
    endproperty
    a_t0_tick: assert property (p_t0_tick) else $error("timer zero missed a fast tick");

    property p_t0_count;
        (m0 == LCT_M16 && cs0 && st_q.tctrl[LCT_TR0] && !pin_fall[0] && !load_sel_in[0]) |=> $stable(st_q.t0);
    endproperty
    a_t0_count: assert property (p_t0_count) else $error("counter moved without an edge");

    property p_m13_ovf;
        (m0 == LCT_M13 && en0 && !load_sel_in[0] && {st_q.t0[15:8], st_q.t0[4:0]} == LCT_MAX13)
            |=> st_q.tctrl[LCT_TF0] && st_q.t0[15:8] == 8'h00 && st_q.t0[4:0] == 5'h00;
    endproperty
    a_m13_ovf: assert property (p_m13_ovf) else $error("13-bit rollover lost");

    property p_m16_ovf;
        (m1 == LCT_M16 && m0 != LCT_SPLIT && en1 && !load_sel_in[1] && st_q.t1 == LCT_MAX16)
            |=> st_q.tctrl[LCT_TF1] && st_q.t1 == 16'h0000;
    endproperty
    a_m16_ovf: assert property (p_m16_ovf) else $error("16-bit wrap lost");

    property p_tf_hold;
        (!st_q.tctrl[LCT_TF0] && !ovf_t0 && !wr_tctrl) |=> !st_q.tctrl[LCT_TF0];
    endproperty
    a_tf_hold: assert property (p_tf_hold) else $error("overflow flag set without cause");

    property p_run_stop;
        (!st_q.tctrl[LCT_TR0] && m0 != LCT_SPLIT && !load_sel_in[0]) |=> $stable(st_q.t0);
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("stopped timer counted");

    property p_level;
        (!st_q.tctrl[LCT_IT0] && !wr_tctrl) |=> st_q.tctrl[LCT_IE0] == !$past(pin_lvl[3]);
    endproperty
    a_level: assert property (p_level) else $error("level flag not following pin");

    property p_t2_off;
        (!t2_run && !load_sel_in[2]) |=> $stable(st_q.t2);
    endproperty
    a_t2_off: assert property (p_t2_off) else $error("timer two ran while off");

    property p_t2_baud;
        (ovf_t2 && timer_two_control_in[LCT_T2_TXB]) |=> baud_tx_out && !t2_ovf_out;
    endproperty
    a_t2_baud: assert property (p_t2_baud) else $error("baud pulse missing");

    property p_t3_reload;
        (ovf_t3 && !load_sel_in[3]) |=> st_q.t3 == {$past(t3_reload_high_in), $past(st_q.t3rll)} && t3_ovf_out;
    endproperty
    a_t3_reload: assert property (p_t3_reload) else $error("timer three reload wrong");

    property p_t2_cap;
        (t2_run && t2_cap_mode && timer_two_control_in[LCT_T2_EXEN] && pin_fall[5])
            |=> t2_capture_out == $past(st_q.t2);
    endproperty
    a_t2_cap: assert property (p_t2_cap) else $error("timer two capture lost");

    property p_split_tf1;
        (m0 == LCT_SPLIT && th0_inc && !load_sel_in[0] && st_q.t0[15:8] == LCT_MAX8)
            |=> st_q.tctrl[LCT_TF1] && st_q.t0[15:8] == 8'h00;
    endproperty
    a_split_tf1: assert property (p_split_tf1) else $error("split high byte overflow lost");

    c_tf0: cover property ($rose(st_q.tctrl[LCT_TF0]));
    c_tf1: cover property ($rose(st_q.tctrl[LCT_TF1]));
    c_t2ovf: cover property (t2_ovf_out);
    c_t3ovf: cover property (t3_ovf_out);
endmodule
`default_nettype wire

/* File: bench/lct_evt_model.sv */
// Partner model: timer event pins, interrupt pins and CPU vectoring acks.
// Assumes every task is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lct_evt_model (
    input  wire logic       mclk_in,   // System clock
    output logic      [5:0] pins_out,  // t0, t1, t2, t2ext, irq0, irq1
    output logic      [3:0] ack_out    // Vectoring: ie0, ie1, tf0, tf1
);
    // Pins idle high, acks idle low
    initial begin
        pins_out = 6'h3f;
        ack_out  = 4'h0;
    end
    task automatic fall(input int k);
        pins_out[k] = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 pins_out[k] = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask
    // Hold a pin at a level
    task automatic set_pin(input int k, input logic v);
        pins_out[k] = v;
    endtask
    task automatic vec(input int k);
        ack_out[k] = 1'b1;
        @(posedge mclk_in);
        #1 ack_out[k] = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/lct_timers_tb_top.sv */
// Testbench for the counter/timer unit: register port, timers zero to three
// and external interrupt flags. Assumes the event model drives all pins.
`timescale 1ns/1ps
`default_nettype none
module lct_timers_tb_top
    import lct_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        t3run = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, mode = 8'h00, t2c = 8'h00, t3rh = 8'h00;
    logic [3:0]  csel = 4'hf, lsel = 4'h0, ack;
    logic [15:0] t2rl = 16'h0000, lval = 16'h0000;
    logic [5:0]  pins;
    logic [7:0]  rdata, tctrl, r;
    logic [15:0] c0, c1, c2, c3, cap, x;
    logic        t2ovf, adc, btx, brx, t3ovf;
    int          n_fail = 0, total_checks = 0;
    // 50 MHz clock
    always #10 mclk = ~mclk;
    lct_evt_model u_lct_evt_model (.mclk_in(mclk), .pins_out(pins), .ack_out(ack));
    lct_timers u_lct_timers (
        .mclk_in(mclk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer_mode_in(mode),
        .clk_sel_in(csel), .timer_two_control_in(t2c), .timer_three_run_in(t3run),
        .t3_reload_high_in(t3rh), .t2_reload_in(t2rl), .load_sel_in(lsel),
        .load_value_in(lval), .t0_pin_in(pins[0]), .t1_pin_in(pins[1]),
        .t2_pin_in(pins[2]), .t2_ext_pin_in(pins[3]), .ext_irq_zero_pin_in(pins[4]),
        .ext_irq_one_pin_in(pins[5]), .vector_ack_in({ack[3], ack[2], ack[1], ack[0]}),
        .tctrl_out(tctrl), .t0_count_out(c0), .t1_count_out(c1), .t2_count_out(c2),
        .t3_count_out(c3), .t2_capture_out(cap), .t2_ovf_out(t2ovf),
        .adc_start_out(adc), .baud_tx_out(btx), .baud_rx_out(brx), .t3_ovf_out(t3ovf));
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Write strobe, then one idle cycle before the next
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        tick(1);
        wr    = 1'b0;
        tick(1);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        tick(1);
        d = rdata;
    endtask
    task automatic load(input int k, input logic [15:0] v);
        lval    = v;
        lsel[k] = 1'b1;
        tick(1);
        lsel[k] = 1'b0;
        tick(1);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return tctrl[LCT_TF0];
            1: return adc;
            2: return btx;
            4: return brx;
            5: return tctrl[LCT_TF1];
            default: return t3ovf;
        endcase
    endfunction
    // Bounded wait for a flag or pulse
    task automatic wait_hi(input int k);
        for (int i = 0; i < 40 && sig(k) !== 1'b1; i++) tick(1);
        if (sig(k) !== 1'b1) begin
            n_fail++;
            $display("[ERR] wait %0d expected 1 seen %b", k, sig(k));
            complete_run();
        end
    endtask
    // Registers after reset, unmapped place, write
    task automatic sc_regs();
        chk("tctrl rst", 16'(LCT_RST_TCTRL), 16'(tctrl));
        rreg(LCT_ADDR_T3RLL, r);
        chk("t3rll rst", 16'(LCT_RST_T3RLL), 16'(r));
        wreg(8'h9d, 8'hff);
        rreg(8'h9d, r);
        chk("unmapped", 16'h0000, 16'(r));
        wreg(LCT_ADDR_TCTRL, 8'h44);
        rreg(LCT_ADDR_TCTRL, r);
        chk("tctrl rd", 16'h0044, 16'(r));
        wreg(LCT_ADDR_TCTRL, 8'h00);
    endtask
    // Timer zero wrap in a given mode, fast tick
    task automatic sc_wrap(input logic [7:0] m, input logic [15:0] v, input logic [15:0] e);
        mode = m;
        load(0, v);
        wreg(LCT_ADDR_TCTRL, 8'h10);
        wait_hi(0);
        chk("t0 wrap", e, {c0[15:8], (m == 8'h00) ? {3'h0, c0[4:0]} : c0[7:0]});
        u_lct_evt_model.vec(2);
        chk("tf0 ack", 16'h0000, 16'(tctrl[LCT_TF0]));
        wreg(LCT_ADDR_TCTRL, 8'h00);
        x = c0;
        tick(5);
        chk("t0 stop", x, c0);
    endtask
    // Slow tick and pin counting
    task automatic sc_src();
        mode = 8'h01;
        csel = 4'he;
        load(0, 16'h0000);
        wreg(LCT_ADDR_TCTRL, 8'h10);
        x = c0;
        tick(24);
        chk("t0 slow", 16'h0002, 16'(c0 - x));
        mode = 8'h05;
        load(0, 16'h0000);
        for (int i = 0; i < 3; i++) u_lct_evt_model.fall(0);
        chk("t0 pins", 16'h0003, c0);
        wreg(LCT_ADDR_TCTRL, 8'h00);
        csel = 4'hf;
    endtask
    // External flags, level then edge, one input per call
    task automatic sc_irq(input int k);
        wreg(LCT_ADDR_TCTRL, 8'h00);
        u_lct_evt_model.set_pin(4 + k, 1'b0);
        tick(3);
        chk("irq lvl", 16'h0001, 16'(tctrl[1 + 2 * k]));
        u_lct_evt_model.set_pin(4 + k, 1'b1);
        tick(3);
        chk("irq lvl off", 16'h0000, 16'(tctrl[1 + 2 * k]));
        wreg(LCT_ADDR_TCTRL, 8'(1 << (2 * k)));
        u_lct_evt_model.fall(4 + k);
        chk("irq edge", 16'h0001, 16'(tctrl[1 + 2 * k]));
        u_lct_evt_model.vec(k);
        chk("irq ack", 16'h0000, 16'(tctrl[1 + 2 * k]));
    endtask
    // Timer three and timer two reloads
    task automatic sc_t23();
        wreg(LCT_ADDR_T3RLL, 8'h5a);
        rreg(LCT_ADDR_T3RLL, r);
        chk("t3rll rd", 16'h005a, 16'(r));
        t3rh = 8'ha5;
        load(3, 16'hfffd);
        t3run = 1'b1;
        wait_hi(3);
        chk("t3 reload", 16'ha55a, c3);
        t3run = 1'b0;
        t2rl = 16'h1234;
        load(2, 16'hfffd);
        t2c = 8'h04;
        wait_hi(1);
        chk("t2 reload", 16'h1234, c2);
        chk("t2 ovf", 16'h0001, 16'(t2ovf));
        t2c = 8'h00;
        load(2, 16'hfffd);
        t2c = 8'h14;
        wait_hi(2);
        chk("t2 baud", 16'h1234, c2);
        t2c = 8'h00;
        load(2, 16'hfffd);
        t2c = 8'h24;
        wait_hi(4);
        chk("t2 rx baud", 16'h1234, c2);
        chk("t2 no ovf", 16'h0000, 16'(t2ovf));
        t2c = 8'h00;
    endtask
    // Timer one 16-bit wrap, then split bytes of timer zero
    task automatic sc_t1();
        mode = 8'h10;
        load(1, 16'hfffd);
        wreg(LCT_ADDR_TCTRL, 8'h40);
        wait_hi(5);
        chk("t1 wrap", 16'h0000, c1);
        u_lct_evt_model.vec(3);
        chk("tf1 ack", 16'h0000, 16'(tctrl[LCT_TF1]));
        wreg(LCT_ADDR_TCTRL, 8'h00);
        mode = 8'h33;
        load(0, 16'hfdfd);
        x = c1;
        wreg(LCT_ADDR_TCTRL, 8'h50);
        wait_hi(0);
        chk("split", 16'h0000, c0);
        chk("split tf1", 16'h0001, 16'(tctrl[LCT_TF1]));
        chk("t1 halt", x, c1);
        wreg(LCT_ADDR_TCTRL, 8'h00);
    endtask
    // Timer two capture on its pin, then counting on its own pin
    task automatic sc_t2cap();
        t2c = 8'h0d;
        load(2, 16'h0100);
        u_lct_evt_model.fall(3);
        chk("t2 cap", 16'h0102, cap);
        t2c = 8'h06;
        load(2, 16'h0000);
        repeat (2) u_lct_evt_model.fall(2);
        chk("t2 pins", 16'h0002, c2);
        t2c = 8'h00;
    endtask
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(1);
        sc_regs();
        sc_wrap(8'h01, 16'hfffd, 16'h0000);
        sc_wrap(8'h00, 16'hff1d, 16'h0000);
        sc_wrap(8'h02, 16'h80fd, 16'h8080);
        sc_t1();
        sc_src();
        sc_irq(0);
        sc_irq(1);
        sc_t23();
        sc_t2cap();
        complete_run();
    end
endmodule
`default_nettype wire
